// ==== verilog/bit_pkg.sv ====
`default_nettype none
// Shared definitions for the termination block
package bit_pkg;

  // Bridge control: upper half of the dword at 0x3C
  localparam logic [7:0] BRIDGE_CONTROL_OFFSET = 8'h3C;
  localparam int BRIDGE_CONTROL_LSB = 16;
  localparam logic [15:0] BRIDGE_CONTROL_RESET = 16'h0000;
  localparam int BC_MASTER_ABORT_MODE_BIT = 5;

  // Claim window in clocks after FRAME# falls
  localparam logic [2:0] DEVSEL_WINDOW_CLOCKS = 3'h5;

  // Attempt counter width; read data on master abort
  localparam int ATTEMPT_WIDTH = 24;
  localparam logic [31:0] MASTER_ABORT_READ_DATA = 32'hFFFF_FFFF;

  // Which bus a status bit belongs to
  localparam int BUS_PRIMARY = 0;
  localparam int BUS_SECONDARY = 1;

  // Kind of transaction forwarded onto the target bus
  typedef enum logic [2:0] {
    KIND_DELAYED_WRITE,
    KIND_READ_SINGLE,
    KIND_READ_PREFETCH,
    KIND_POSTED_WRITE,
    KIND_SPECIAL_CYCLE
  } bit_kind_type;

  // Answer to be returned to the originating initiator
  typedef enum logic [1:0] {
    RESP_TRDY,
    RESP_DISCONNECT,
    RESP_RETRY,
    RESP_TARGET_ABORT
  } bit_resp_code_type;

  // Queued request presented to the block
  typedef struct packed {
    logic valid;
    bit_kind_type kind;
    logic mem_write_invalidate;
    logic multi_phase;
    logic to_secondary;
    logic [31:2] dword_addr;
    logic [15:0] dword_count;
  } bit_req_type;

  // Target-bus inputs, active low as on the bus
  typedef struct packed {
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
    logic gnt_n;
  } bit_bus_in_type;

  // System-error enables from the command and event-disable registers
  typedef struct packed {
    logic serr_enable;
    logic disable_posted_master_abort;
    logic disable_retry_limit;
  } bit_serr_ctrl_type;

  // Answer for the delayed-transaction return queue
  typedef struct packed {
    logic valid;
    bit_resp_code_type code;
    logic all_ones_data;
  } bit_resp_type;

  // One-cycle set pulses for status registers, indexed by bus
  typedef struct packed {
    logic [1:0] rcv_master_abort;
    logic [1:0] rcv_target_abort;
    logic [1:0] sig_target_abort;
  } bit_status_set_type;

endpackage
`default_nettype wire

// ==== verilog/bit_attempt_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
// Counts target retries of the active queued transaction
module bit_attempt_counter #(
  parameter int WIDTH = 24,
  parameter int unsigned LIMIT = 2**24
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic bump,
  output logic [WIDTH-1:0] count,
  output logic at_last
);
  // Count held while the last permitted attempt runs
  localparam logic [WIDTH-1:0] LAST_VALUE = WIDTH'(LIMIT - 1);

  logic [WIDTH-1:0] count_q; // Retries seen so far

  // Clear wins so a fresh request never inherits an old count
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (bump) begin
      count_q <= count_q + WIDTH'(1);
    end
  end

  assign count = count_q;
  assign at_last = (count_q == LAST_VALUE);

endmodule // bit_attempt_counter
`default_nettype wire

// ==== verilog/bit_initiator_termination.sv ====
// Summary of operation
// - DEVSEL within five clocks: normal master termination
// - Delayed write ends after one Dword
// - Non-prefetchable read ends after one Dword
// - Prefetchable read ends at prefetch boundary
// - Posted write ends when all data delivered
// - Burst ends on latency expiry without grant
// - Target retry, disconnect, abort end transaction
// - Latency-cut posted write resumes at next Dword
// - Latency-cut prefetch read is not repeated
// - No DEVSEL in five clocks: master abort
// - Abort mode 0: TRDY, all-ones read data
// - Abort mode 1: target abort, signaled bit
// - Posted master abort drops data, sets status
// - Posted master abort SERR when mode, enabled
// - Special cycle master abort is normal
// - Delayed write disconnect only if multi-phase
// - Delayed write retry: retry initiator, reattempt
// - Delayed write target abort: return, set bits
// - Reissue delayed write until done or limit
// - Retry limit raises SERR when enabled
// - Retry limit discards request, target abort
`timescale 1ns/10ps
`default_nettype none
module bit_initiator_termination #(
  parameter int unsigned ATTEMPT_LIMIT = 2**24,
  parameter int PREFETCH_BOUNDARY_LOG2 = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_offset,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic [7:0] master_latency_value,
  input wire bit_pkg::bit_serr_ctrl_type serr_ctrl,
  input wire bit_pkg::bit_req_type req,
  output logic req_done,
  output logic data_xfer,
  output logic [31:2] curr_dword_addr,
  input wire bit_pkg::bit_bus_in_type bus_in,
  output logic frame_n_out,
  output logic irdy_n_out,
  output logic master_oe,
  output var bit_pkg::bit_resp_type resp,
  output var bit_pkg::bit_status_set_type status_set,
  output logic primary_system_error_out
);
  import bit_pkg::*;

  // Master sequence on the target bus
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_RELEASE} bit_state_type;

  bit_state_type state_q; // Current bus phase
  logic frame_n_q; // FRAME# as driven
  logic irdy_n_q; // IRDY# as driven
  logic oe_q; // Master owns FRAME#/IRDY#
  logic [2:0] wait_cnt_q; // Clocks since FRAME# was asserted
  logic devsel_seen_q; // Target has claimed this attempt
  logic xfer_seen_q; // At least one data phase completed
  logic [7:0] lat_cnt_q; // Master latency timer
  logic active_q; // A request is held (possibly between attempts)
  bit_req_type cur_q; // Held request
  logic [31:2] addr_q; // Next undelivered Dword address
  logic [15:0] remain_q; // Posted Dwords still to deliver
  logic [15:0] bridge_control_q; // Bridge control register
  logic [31:0] cfg_rdata_q; // Registered read data
  logic req_done_q; // Request retired pulse
  logic data_xfer_q; // Dword moved pulse
  bit_resp_type resp_q; // Answer for the initiator side
  bit_status_set_type status_q; // Status set pulses
  logic serr_q; // System error pulse

  // Decoded bus levels, active high
  logic devsel, trdy, stop, gnt, frame_on, xfer, start, load_new;
  logic master_abort, target_abort, retry, disconnect, normal_end, end_now;
  logic lat_stop, next_is_last, limit_hit, finish, abort_mode, attempt_at_last;
  logic [15:0] remain_after;

  // Single-data-phase kinds; used when framing and for the latency cut
  function automatic logic is_single(input bit_kind_type k);
    return (k == KIND_DELAYED_WRITE) || (k == KIND_READ_SINGLE) ||
           (k == KIND_SPECIAL_CYCLE);
  endfunction

  // Kinds whose outcome travels back to the initiator
  function automatic logic is_delayed(input bit_kind_type k);
    return k != KIND_POSTED_WRITE;
  endfunction

  // Read kinds get all-ones data on a soft master abort
  function automatic logic is_read(input bit_kind_type k);
    return (k == KIND_READ_SINGLE) || (k == KIND_READ_PREFETCH);
  endfunction

  // True when the Dword at this address is the last before a boundary
  function automatic logic last_before_boundary(input logic [31:2] a);
    return &a[PREFETCH_BOUNDARY_LOG2+1:2];
  endfunction

  assign devsel = ~bus_in.devsel_n;
  assign trdy = ~bus_in.trdy_n;
  assign stop = ~bus_in.stop_n;
  assign gnt = ~bus_in.gnt_n;
  assign frame_on = ~frame_n_q;
  assign abort_mode = bridge_control_q[BC_MASTER_ABORT_MODE_BIT];

  // Start an attempt only with the grant; a held request restarts itself
  assign start = (state_q == ST_IDLE) && gnt && (active_q || req.valid);
  assign load_new = start && !active_q;

  // A data phase completes when IRDY# and TRDY# meet with DEVSEL#
  assign xfer = (state_q == ST_DATA) && !irdy_n_q && trdy && devsel;
  assign remain_after = remain_q - {15'h0000, xfer};

  // Target terminations, classified on the bus signals of this clock
  assign master_abort = (state_q == ST_DATA) && !devsel_seen_q && !devsel &&
                        (wait_cnt_q == DEVSEL_WINDOW_CLOCKS);
  assign target_abort = (state_q == ST_DATA) && stop && !devsel && devsel_seen_q;
  assign retry = (state_q == ST_DATA) && stop && devsel && !trdy && !xfer_seen_q;
  assign disconnect = (state_q == ST_DATA) && stop && devsel && !retry;
  assign normal_end = xfer && !stop && !frame_on;
  assign end_now = master_abort || target_abort || retry || disconnect ||
                   normal_end;

  // Latency cut applies to bursts other than memory write and invalidate
  assign lat_stop = !is_single(cur_q.kind) && !cur_q.mem_write_invalidate &&
                    (lat_cnt_q >= master_latency_value) && !gnt;

  // The next data phase is the final one of this burst
  always_comb begin
    next_is_last = 1'b0;
    if (cur_q.kind == KIND_POSTED_WRITE) begin
      next_is_last = (remain_after == 16'h0001);
    end else if (cur_q.kind == KIND_READ_PREFETCH) begin
      next_is_last = last_before_boundary(addr_q + 30'h1);
    end
  end

  // Retry limit reached on the final permitted attempt
  assign limit_hit = retry && attempt_at_last;

  // Whether this end retires the held request or it must go again
  always_comb begin
    finish = 1'b1;
    if (retry && !attempt_at_last) begin
      finish = 1'b0;
    end else if (cur_q.kind == KIND_POSTED_WRITE && !master_abort &&
                 !target_abort && !limit_hit) begin
      finish = (remain_after == 16'h0000);
    end
  end

  // Retry attempts of the held request
  bit_attempt_counter #(
    .WIDTH(ATTEMPT_WIDTH),
    .LIMIT(ATTEMPT_LIMIT)
  ) u_attempts (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(load_new),
    .bump(retry),
    .count(),
    .at_last(attempt_at_last)
  );

  // Bus phase sequencing: FRAME#, IRDY# and their enable
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      frame_n_q <= 1'b1;
      irdy_n_q <= 1'b1;
      oe_q <= 1'b0;
      wait_cnt_q <= 3'h0;
      devsel_seen_q <= 1'b0;
      xfer_seen_q <= 1'b0;
      lat_cnt_q <= 8'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          // Address phase begins with FRAME# low
          if (start) begin
            frame_n_q <= 1'b0;
            oe_q <= 1'b1;
            state_q <= ST_ADDR;
          end
          wait_cnt_q <= 3'h0;
          devsel_seen_q <= 1'b0;
          xfer_seen_q <= 1'b0;
          lat_cnt_q <= 8'h00;
        end
        ST_ADDR: begin
          // Single-phase kinds drop FRAME# with the first IRDY#
          irdy_n_q <= 1'b0;
          frame_n_q <= is_single(cur_q.kind);
          wait_cnt_q <= 3'h1;
          lat_cnt_q <= 8'h01;
          state_q <= ST_DATA;
        end
        ST_DATA: begin
          // Saturate so the counters cannot wrap during long bursts
          if (wait_cnt_q != 3'h7) begin
            wait_cnt_q <= wait_cnt_q + 3'h1;
          end
          if (lat_cnt_q != 8'hFF) begin
            lat_cnt_q <= lat_cnt_q + 8'h01;
          end
          devsel_seen_q <= devsel_seen_q | devsel;
          xfer_seen_q <= xfer_seen_q | xfer;
          if (end_now) begin
            // Master abort with FRAME# still low keeps IRDY# one more clock
            frame_n_q <= 1'b1;
            irdy_n_q <= !(master_abort && frame_on);
            state_q <= ST_RELEASE;
          end else if (frame_on && (lat_stop || (xfer && next_is_last))) begin
            frame_n_q <= 1'b1;
          end
        end
        ST_RELEASE: begin
          // Drive deasserted levels for a clock, then float
          irdy_n_q <= 1'b1;
          frame_n_q <= 1'b1;
          oe_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Held request and its retirement
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= 1'b0;
      cur_q <= '0;
      req_done_q <= 1'b0;
    end else begin
      req_done_q <= 1'b0;
      if (load_new) begin
        active_q <= 1'b1;
        cur_q <= req;
      end else if (end_now && finish) begin
        // Prefetch cut by latency is retired here, never refetched
        active_q <= 1'b0;
        req_done_q <= 1'b1;
      end
    end
  end

  // Address and count track each delivered Dword for resumption
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= '0;
      remain_q <= 16'h0000;
      data_xfer_q <= 1'b0;
    end else begin
      data_xfer_q <= xfer;
      if (load_new) begin
        addr_q <= req.dword_addr;
        remain_q <= req.dword_count;
      end else if (xfer) begin
        addr_q <= addr_q + 30'h1;
        remain_q <= remain_after;
      end
    end
  end

  // Answer for the initiator of a delayed transaction
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_q <= '0;
    end else begin
      resp_q <= '0;
      if (end_now && is_delayed(cur_q.kind)) begin
        resp_q.valid <= 1'b1;
        if (limit_hit || target_abort) begin
          resp_q.code <= RESP_TARGET_ABORT;
        end else if (retry) begin
          resp_q.code <= RESP_RETRY;
        end else if (master_abort && cur_q.kind != KIND_SPECIAL_CYCLE) begin
          if (abort_mode) begin
            resp_q.code <= RESP_TARGET_ABORT;
          end else begin
            resp_q.code <= RESP_TRDY;
            resp_q.all_ones_data <= is_read(cur_q.kind);
          end
        end else if (cur_q.multi_phase) begin
          // Normal, disconnect, or expected special-cycle master abort
          resp_q.code <= RESP_DISCONNECT;
        end else begin
          resp_q.code <= RESP_TRDY;
        end
      end
    end
  end

  // Status set pulses and the primary system-error output
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= '0;
      serr_q <= 1'b0;
    end else begin
      status_q <= '0;
      serr_q <= 1'b0;
      if (master_abort && cur_q.kind != KIND_SPECIAL_CYCLE) begin
        // Special cycles expect master abort, so no status is recorded
        status_q.rcv_master_abort[cur_q.to_secondary] <= 1'b1;
        if (is_delayed(cur_q.kind) && abort_mode) begin
          status_q.sig_target_abort[!cur_q.to_secondary] <= 1'b1;
        end
        if (cur_q.kind == KIND_POSTED_WRITE && abort_mode && serr_ctrl.serr_enable &&
            !serr_ctrl.disable_posted_master_abort) begin
          serr_q <= 1'b1;
        end
      end
      if (target_abort) begin
        status_q.rcv_target_abort[cur_q.to_secondary] <= 1'b1;
        if (is_delayed(cur_q.kind)) begin
          status_q.sig_target_abort[!cur_q.to_secondary] <= 1'b1;
        end
      end
      if (limit_hit && serr_ctrl.serr_enable && !serr_ctrl.disable_retry_limit) begin
        serr_q <= 1'b1;
      end
    end
  end

  // Bridge control register; only the two upper byte lanes exist
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      bridge_control_q <= BRIDGE_CONTROL_RESET;
    end else if (cfg_write && cfg_offset == BRIDGE_CONTROL_OFFSET) begin
      for (int b = 0; b < 2; b++) begin
        if (cfg_byte_en[b + 2]) begin
          bridge_control_q[b*8 +: 8] <= cfg_wdata[BRIDGE_CONTROL_LSB + b*8 +: 8];
        end
      end
    end
  end

  // Read data follows the offset one clock later; other offsets read zero
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata_q <= 32'h0000_0000;
    end else if (cfg_offset == BRIDGE_CONTROL_OFFSET) begin
      cfg_rdata_q <= {bridge_control_q, 16'h0000};
    end else begin
      cfg_rdata_q <= 32'h0000_0000;
    end
  end

  assign cfg_rdata = cfg_rdata_q;
  assign req_done = req_done_q;
  assign data_xfer = data_xfer_q;
  assign curr_dword_addr = addr_q;
  assign frame_n_out = frame_n_q;
  assign irdy_n_out = irdy_n_q;
  assign master_oe = oe_q;
  assign resp = resp_q;
  assign status_set = status_q;
  assign primary_system_error_out = serr_q;

endmodule // bit_initiator_termination
`default_nettype wire

// ==== verif/bit_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the termination block
module bit_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] cfg_offset,
  input wire logic [31:0] cfg_rdata,
  input wire bit_pkg::bit_serr_ctrl_type serr_ctrl,
  input wire bit_pkg::bit_req_type req,
  input wire logic req_done,
  input wire logic data_xfer,
  input wire bit_pkg::bit_bus_in_type bus_in,
  input wire logic frame_n_out,
  input wire logic irdy_n_out,
  input wire logic master_oe,
  input wire bit_pkg::bit_resp_type resp,
  input wire bit_pkg::bit_status_set_type status_set,
  input wire logic primary_system_error_out
);
  import bit_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  // Address phase of a new attempt
  sequence s_addr;
    $fell(frame_n_out);
  endsequence
  // Five data cycles with nobody claiming
  sequence s_unclaimed;
    bus_in.devsel_n [*5];
  endsequence
  property p_abort_timing;
    s_addr ##1 s_unclaimed |=> ##[0:1] (status_set.rcv_master_abort != 2'h0 || resp.valid);
  endproperty
  a_abort_timing: assert property (p_abort_timing) else $error("no abort after silence");
  // An abort report needs five silent cycles before it
  property p_abort_silence;
    status_set.rcv_master_abort != 2'h0 |-> $past(bus_in.devsel_n, 1) && $past(bus_in.devsel_n, 2)
      && $past(bus_in.devsel_n, 3) && $past(bus_in.devsel_n, 4) && $past(bus_in.devsel_n, 5);
  endproperty
  a_abort_silence: assert property (p_abort_silence) else $error("abort despite claim");
  property p_ones_trdy;
    resp.valid && resp.all_ones_data |-> resp.code == RESP_TRDY;
  endproperty
  a_ones_trdy: assert property (p_ones_trdy) else $error("all-ones without ready");
  property p_single;
    data_xfer && req.kind inside {KIND_DELAYED_WRITE, KIND_READ_SINGLE} |-> req_done;
  endproperty
  a_single: assert property (p_single) else $error("single dword kept going");
  // Stop ends the burst: frame first, then irdy
  property p_stop_ends;
    !bus_in.stop_n && !irdy_n_out |=> frame_n_out ##[0:1] irdy_n_out;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("stop ignored");
  property p_serr_enabled;
    primary_system_error_out |-> serr_ctrl.serr_enable;
  endproperty
  a_serr_enabled: assert property (p_serr_enabled) else $error("error out while off");
  property p_done_idle;
    req_done |-> frame_n_out;
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("retired mid-frame");
  property p_oe_release;
    $rose(irdy_n_out) && frame_n_out |=> !master_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("bus held after end");
  property p_cfg_unmapped;
    cfg_offset != 8'h3C |=> cfg_rdata == 32'h0000_0000;
  endproperty
  a_cfg_unmapped: assert property (p_cfg_unmapped) else $error("unmapped read not zero");
  property p_ta_status;
    status_set.rcv_target_abort != 2'h0 && req.kind == KIND_DELAYED_WRITE |-> resp.valid
      && resp.code == RESP_TARGET_ABORT && status_set.sig_target_abort != 2'h0;
  endproperty
  a_ta_status: assert property (p_ta_status) else $error("target abort not passed");
  property p_special_quiet;
    status_set.rcv_master_abort != 2'h0 |-> req.kind != KIND_SPECIAL_CYCLE;
  endproperty
  a_special_quiet: assert property (p_special_quiet) else $error("special sets abort");
endmodule // bit_checker
bind bit_initiator_termination bit_checker u_checker (.*);
`default_nettype wire

// ==== verif/bit_target_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Far-bus target; it drives its lines high itself while idle
module bit_target_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic frame_n_out,
  input wire logic irdy_n_out,
  input wire logic [2:0] claim_delay,
  input wire logic [1:0] ending,
  output logic devsel_n,
  output logic trdy_n,
  output logic stop_n
);
  logic active_q;
  logic [2:0] age_q;
  // Claim after claim_delay data cycles (0 never), then end: 0 normal 1 disc 2 retry 3 abort
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      active_q <= 1'b0;
      age_q <= 3'h0;
      devsel_n <= 1'b1;
      trdy_n <= 1'b1;
      stop_n <= 1'b1;
    end else if (!active_q) begin
      // Address phase seen
      if (!frame_n_out) begin
        active_q <= 1'b1;
        age_q <= 3'h1;
        devsel_n <= (claim_delay != 3'h1);
      end
    end else if (frame_n_out && irdy_n_out) begin
      // Master let go: release everything
      active_q <= 1'b0;
      devsel_n <= 1'b1;
      trdy_n <= 1'b1;
      stop_n <= 1'b1;
    end else if (devsel_n && stop_n) begin
      age_q <= age_q + 3'h1;
      devsel_n <= (claim_delay != age_q + 3'h1);
    end else begin
      // Abort drops devsel after one claimed cycle
      trdy_n <= ending[1];
      stop_n <= (ending == 2'h0);
      devsel_n <= (ending == 2'h3);
    end
  end
endmodule // bit_target_model
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    comparisons++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module testbench;
  import bit_pkg::*;
  localparam int LIMIT = 8; // Short retry limit keeps the run brief
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic cfg_write = 1'b0;
  logic [7:0] cfg_offset = 8'h00;
  logic [3:0] cfg_byte_en = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [31:0] cfg_rdata;
  logic [7:0] latency = 8'hFF;
  bit_serr_ctrl_type serr_ctrl = '0;
  bit_req_type req = '0;
  logic req_done, data_xfer, frame_n_out, irdy_n_out, master_oe, serr_out, done, prev_frame;
  logic [31:2] cur_addr;
  bit_resp_type resp, last;
  bit_status_set_type status_set, stat;
  logic devsel_n, trdy_n, stop_n, m, tosec, mwi;
  logic gnt_n = 1'b0;
  logic gnt_drop = 1'b0; // Withhold grant in frames
  logic [2:0] claim = 3'h1;
  logic [1:0] ending = 2'h0;
  int miscompares = 0, comparisons = 0, cycles = 0, n_xfer, n_frame, n_serr, n_retry, n;
  always #2 sys_clk = ~sys_clk;
  bit_initiator_termination #(.ATTEMPT_LIMIT(LIMIT), .PREFETCH_BOUNDARY_LOG2(4)) dut (
    .sys_clk, .reset_n, .cfg_write, .cfg_offset, .cfg_byte_en, .cfg_wdata, .cfg_rdata,
    .master_latency_value(latency), .serr_ctrl, .req, .req_done, .data_xfer,
    .curr_dword_addr(cur_addr), .bus_in(bit_bus_in_type'({devsel_n, trdy_n, stop_n, gnt_n})),
    .frame_n_out, .irdy_n_out, .master_oe, .resp, .status_set, .primary_system_error_out(serr_out));
  bit_target_model target (.sys_clk, .reset_n, .frame_n_out, .irdy_n_out,
    .claim_delay(claim), .ending, .devsel_n, .trdy_n, .stop_n);
  // Tally outputs each edge; the ceiling is far past the run
  always @(posedge sys_clk) begin
    cycles++;
    if (prev_frame && !frame_n_out) n_frame++;
    prev_frame = frame_n_out;
    if (data_xfer) n_xfer++;
    if (resp.valid) last = resp;
    if (resp.valid && resp.code == RESP_RETRY) n_retry++;
    if (serr_out) n_serr++;
    stat = stat | status_set;
    done = done | req_done;
    gnt_n <= gnt_drop && !frame_n_out;
    if (cycles == 30000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One register access; read data is valid on return
  task automatic cfg(input logic [7:0] o, input logic [3:0] be, input logic [31:0] d, input logic w);
    @(posedge sys_clk);
    #1;
    cfg_write = w;
    cfg_offset = o;
    cfg_byte_en = be;
    cfg_wdata = d;
    @(posedge sys_clk);
    #1;
    cfg_write = 1'b0;
  endtask
  task automatic set_mode(input logic md);
    cfg(8'h3C, 4'hC, {10'h000, md, 5'h00, 16'h0000}, 1'b1);
  endtask
  // Hold one request until it retires
  task automatic run(input bit_kind_type k, input logic [31:2] a, input logic [15:0] cnt,
                     input logic [2:0] dly, input logic [1:0] how);
    int w;
    @(posedge sys_clk);
    #1;
    claim = dly;
    ending = how;
    {n_xfer, n_frame, n_serr, n_retry} = '0;
    {done, stat, last} = '0;
    req = '{1'b1, k, mwi, m, tosec, a, cnt};
    w = 0;
    while (!done && w < 400) begin
      @(posedge sys_clk);
      #1;
      w++;
    end
    req.valid = 1'b0;
    `CHK("req_done", 1'b1, done)
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    void'($urandom(32'hBA9B8EEE));
    {m, tosec, mwi} = 3'h0;
    repeat (12) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    // Byte lanes 2 and 3 only; other offsets read zero
    cfg(8'h3C, 4'hC, 32'h5A20_0000, 1'b1);
    cfg(8'h3C, 4'h0, 32'h0000_0000, 1'b0);
    `CHK("bridge_control", 32'h5A20_0000, cfg_rdata)
    cfg(8'h3C, 4'h4, 32'hFFFF_FFFF, 1'b1);
    cfg(8'h3C, 4'h0, 32'h0000_0000, 1'b0);
    `CHK("low lane", 32'h5AFF_0000, cfg_rdata)
    cfg(8'h40, 4'hF, 32'hFFFF_FFFF, 1'b1);
    `CHK("unmapped", 32'h0000_0000, cfg_rdata)
    set_mode(1'b0);
    $display("test registers done");
    // Claimed single Dwords, random claim time, normal or disconnect ending
    for (int i = 0; i < 8; i++) begin
      m = 1'($urandom);
      run(i < 4 ? KIND_DELAYED_WRITE : KIND_READ_SINGLE, 30'($urandom), 16'h0004,
          3'(1 + $urandom % 5), 2'(i % 2));
      `CHK("xfers", 1, n_xfer)
      `CHK("answer", m ? RESP_DISCONNECT : RESP_TRDY, last.code)
    end
    m = 1'b1;
    run(KIND_READ_PREFETCH, 30'h0000_000E, 16'h0010, 3'h2, 2'h0);
    `CHK("prefetch xfers", 2, n_xfer)
    n = 2 + $urandom % 6;
    run(KIND_POSTED_WRITE, 30'h0000_0100, 16'(n), 3'h3, 2'h0);
    `CHK("posted xfers", n, n_xfer)
    `CHK("next addr", 30'h0000_0100 + 30'(n), cur_addr)
    $display("test claimed transfers done");
    // Latency expiry, grant withheld; invalidate exempt
    latency = 8'h02;
    gnt_drop = 1'b1;
    for (int i = 0; i < 2; i++) begin
      mwi = i[0];
      run(KIND_POSTED_WRITE, 30'h0000_0200, 16'h000C, 3'h1, 2'h0);
      `CHK("resumed xfers", 12, n_xfer)
      `CHK("cut", !mwi, n_frame > 1)
    end
    mwi = 1'b0;
    run(KIND_READ_PREFETCH, 30'h0000_0300, 16'h0010, 3'h1, 2'h0);
    `CHK("prefetch frames", 1, n_frame)
    latency = 8'hFF;
    gnt_drop = 1'b0;
    $display("test latency done");
    // Unclaimed delayed write and read, both abort modes
    m = 1'b0;
    for (int i = 0; i < 4; i++) begin
      set_mode(i[1]);
      tosec = 1'($urandom);
      run(i[0] ? KIND_READ_SINGLE : KIND_DELAYED_WRITE, 30'($urandom), 16'h0001, 3'h0, 2'h0);
      `CHK("rcv abort", {tosec, !tosec}, stat.rcv_master_abort)
      `CHK("abort answer", i[1] ? RESP_TARGET_ABORT : RESP_TRDY, last.code)
      `CHK("all ones", !i[1] && i[0], last.all_ones_data)
      `CHK("sig abort", {i[1] && !tosec, i[1] && tosec}, stat.sig_target_abort)
    end
    // Posted abort: dropped, error out only if enabled
    serr_ctrl.serr_enable = 1'b1;
    for (int i = 0; i < 3; i++) begin
      set_mode(i != 0);
      serr_ctrl.disable_posted_master_abort = (i == 2);
      run(KIND_POSTED_WRITE, 30'h0000_0040, 16'h0003, 3'h0, 2'h0);
      `CHK("error out", int'(i == 1), n_serr)
      `CHK("posted rcv abort", {tosec, !tosec}, stat.rcv_master_abort)
      `CHK("no retry", 1, n_frame)
    end
    set_mode(1'b0);
    for (int i = 0; i < 2; i++) begin
      m = i[0];
      run(KIND_SPECIAL_CYCLE, 30'h0000_0000, 16'h0002, 3'h0, 2'h0);
      `CHK("special status", 2'h0, stat.rcv_master_abort)
      `CHK("special answer", m ? RESP_DISCONNECT : RESP_TRDY, last.code)
    end
    $display("test master abort done");
    // Target abort, then retries up to the limit
    m = 1'b0;
    tosec = 1'b1;
    run(KIND_DELAYED_WRITE, 30'h0000_0080, 16'h0001, 3'h2, 2'h3);
    `CHK("ta answer", RESP_TARGET_ABORT, last.code)
    `CHK("ta status", 4'h9, {stat.rcv_target_abort, stat.sig_target_abort})
    for (int i = 0; i < 2; i++) begin
      serr_ctrl.disable_retry_limit = i[0];
      run(KIND_DELAYED_WRITE, 30'h0000_0090, 16'h0001, 3'h1, 2'h2);
      `CHK("attempts", LIMIT, n_frame)
      `CHK("retries passed", 1'b1, n_retry != 0)
      `CHK("limit answer", RESP_TARGET_ABORT, last.code)
      `CHK("limit error", int'(i == 0), n_serr)
    end
    $display("test target termination done");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
